// ---- core/ubf_pkg.sv ----
// constants, types and register map of the baud and frame configuration block
package ubf_pkg;

   // register byte offsets on the axi4-lite port
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_MODE   = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_DIV    = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_RXDATA = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_STAT   = 4'hc;

   // serial_mode_control field positions
   localparam int unsigned MODE_STOP  = 0;
   localparam int unsigned MODE_PD_LO = 1;
   localparam int unsigned MODE_PD_HI = 2;
   localparam int unsigned MODE_HSEL  = 3;
   localparam int unsigned MODE_RX_POLARITY_INVERT = 4;
   localparam int unsigned MODE_W     = 5;

   localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
   localparam logic [15:0]       DIV_RST  = 16'h0000;

   // parity_data_select codes
   localparam logic [1:0] PD_NINE = 2'h3;
   localparam logic [1:0] PD_ODD  = 2'h2;
   localparam logic [1:0] PD_EVEN = 2'h1;
   localparam logic [1:0] PD_NONE = 2'h0;

   // baud-timer ticks per bit
   localparam int unsigned PRESCALE_STD = 16;
   localparam int unsigned PRESCALE_HS  = 4;
   localparam logic [3:0]  LAST_STD = 4'(PRESCALE_STD - 1);
   localparam logic [3:0]  LAST_HS  = 4'(PRESCALE_HS - 1);
   localparam logic [3:0]  HALF_STD = 4'(PRESCALE_STD / 2 - 1);
   localparam logic [3:0]  HALF_HS  = 4'(PRESCALE_HS / 2 - 1);

   localparam logic [3:0] LAST_BIT_8 = 4'h7;
   localparam logic [3:0] LAST_BIT_9 = 4'h8;

   // receive data and status fields
   localparam int unsigned RXD_PERR  = 9;
   localparam int unsigned RXD_FERR  = 10;
   localparam int unsigned RXD_VALID = 31;
   localparam int unsigned ST_NEMPTY = 0;
   localparam int unsigned ST_FULL   = 1;
   localparam int unsigned ST_OVR    = 2;
   localparam int unsigned ST_PERR   = 3;
   localparam int unsigned ST_FERR   = 4;
   localparam int unsigned ST_IDLE   = 5;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       ferr;
      logic       perr;
      logic [8:0] data;
   } ubf_word_s;

   typedef enum logic [5:0] {
      RX_IDLE   = 6'h01,
      RX_START  = 6'h02,
      RX_DATA   = 6'h04,
      RX_PARITY = 6'h08,
      RX_STOP   = 6'h10,
      RX_HOLD   = 6'h20
   } ubf_rx_state_e;

endpackage

// ---- core/ubf_top.sv ----
// baud timer, character-format receiver and axi4-lite registers
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
module ubf_top #(
   parameter int unsigned DEPTH = 2
) (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [ubf_pkg::ADDR_W-1:0] s_awaddr,
   input  wire logic                       s_awvalid,
   output logic                            s_awready,
   input  wire logic [31:0]                s_wdata,
   input  wire logic [3:0]                 s_wstrb,
   input  wire logic                       s_wvalid,
   output logic                            s_wready,
   output logic [1:0]                      s_bresp,
   output logic                            s_bvalid,
   input  wire logic                       s_bready,
   input  wire logic [ubf_pkg::ADDR_W-1:0] s_araddr,
   input  wire logic                       s_arvalid,
   output logic                            s_arready,
   output logic [31:0]                     s_rdata,
   output logic [1:0]                      s_rresp,
   output logic                            s_rvalid,
   input  wire logic                       s_rready,
   input  wire logic                       serial_receive_input,
   output logic                            baud_tick,
   output logic                            bit_tick
);

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [ubf_pkg::MODE_W-1:0] serial_mode_control;
   logic [15:0]                baud_divisor;
   logic [15:0]                baud_timer;
   logic [3:0]                 pre_cnt;
   logic                       high_speed_baud_select;
   logic                       rx_polarity_invert;
   logic [1:0]                 parity_data_select;
   logic                       stop_bit_select;
   logic [3:0]                 bit_last;
   logic [3:0]                 half_last;

   // write channel, read take and buffer pop
   logic [ubf_pkg::ADDR_W-1:0] aw_addr;
   logic                       aw_full;
   logic [31:0]                w_data;
   logic [3:0]                 w_strb;
   logic                       w_full;
   logic                       do_write;
   logic                       div_wr;
   logic                       stat_wr;
   logic                       ar_take;
   logic                       pop;

   // receiver
   logic [2:0]                 rx_sync;
   logic                       rx_level;
   logic                       line;
   ubf_pkg::ubf_rx_state_e     rx_state;
   logic [3:0]                 sc;
   logic [3:0]                 bit_cnt;
   logic                       stop_cnt;
   logic [8:0]                 sh;
   logic                       par_bit;
   logic                       ferr;
   logic                       sample;
   logic                       half_hit;
   logic                       perr;
   ubf_pkg::ubf_word_s         push_word;
   logic                       push_valid;
   logic                       push_ready;

   // buffer and sticky status
   ubf_pkg::ubf_word_s         mem [DEPTH];
   logic [PW-1:0]              wr_ptr;
   logic [PW-1:0]              rd_ptr;
   logic [PW:0]                count;
   logic                       out_valid;
   logic                       ovr_flag;
   logic                       perr_flag;
   logic                       ferr_flag;

   assign stop_bit_select        = serial_mode_control[ubf_pkg::MODE_STOP];
   assign parity_data_select     = serial_mode_control[ubf_pkg::MODE_PD_HI:ubf_pkg::MODE_PD_LO];
   assign high_speed_baud_select = serial_mode_control[ubf_pkg::MODE_HSEL];
   assign rx_polarity_invert     = serial_mode_control[ubf_pkg::MODE_RX_POLARITY_INVERT];

   assign bit_last  = high_speed_baud_select ? ubf_pkg::LAST_HS : ubf_pkg::LAST_STD;
   assign half_last = high_speed_baud_select ? ubf_pkg::HALF_HS : ubf_pkg::HALF_STD;

   assign do_write = aw_full & w_full & ~s_bvalid;
   assign div_wr   = do_write & (aw_addr == ubf_pkg::OFS_DIV) & (|w_strb[1:0]);
   assign stat_wr  = do_write & (aw_addr == ubf_pkg::OFS_STAT) & w_strb[0];
   assign ar_take  = s_arvalid & s_arready;
   assign pop      = ar_take & (s_araddr == ubf_pkg::OFS_RXDATA) & out_valid;

   // aclk is the instruction clock; the oscillator halving sits upstream
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_timer <= '0;
         baud_tick  <= 1'b0;
      end else if (div_wr) begin
         baud_timer <= '0;
         baud_tick  <= 1'b0;
      end else if (baud_timer == baud_divisor) begin
         baud_timer <= '0;
         baud_tick  <= 1'b1;
      end else begin
         baud_timer <= baud_timer + 16'h0001;
         baud_tick  <= 1'b0;
      end
   end

   // free bit-rate pulse, for the transmit side of the port
   always_ff @(posedge aclk) begin
      if (!aresetn || div_wr) begin
         pre_cnt  <= '0;
         bit_tick <= 1'b0;
      end else if (baud_tick && pre_cnt >= bit_last) begin
         pre_cnt  <= '0;
         bit_tick <= 1'b1;
      end else begin
         pre_cnt  <= baud_tick ? pre_cnt + 4'h1 : pre_cnt;
         bit_tick <= 1'b0;
      end
   end

   // write address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full   <= 1'b0;
         aw_addr   <= '0;
         s_awready <= 1'b0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_full <= 1'b1;
            aw_addr <= s_awaddr;
         end else if (do_write) begin
            aw_full <= 1'b0;
         end
         s_awready <= ~((s_awvalid & s_awready) | (aw_full & ~do_write));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full   <= 1'b0;
         w_data   <= '0;
         w_strb   <= '0;
         s_wready <= 1'b0;
      end else begin
         if (s_wvalid && s_wready) begin
            w_full <= 1'b1;
            w_data <= s_wdata;
            w_strb <= s_wstrb;
         end else if (do_write) begin
            w_full <= 1'b0;
         end
         s_wready <= ~((s_wvalid & s_wready) | (w_full & ~do_write));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_bvalid <= 1'b0;
         s_bresp  <= ubf_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_bvalid <= 1'b1;
         s_bresp  <= (aw_addr[1:0] == 2'h0) ? ubf_pkg::RESP_OKAY : ubf_pkg::RESP_SLVERR;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end

   // mode change mid-frame takes effect on the next sample; software should idle first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_mode_control <= ubf_pkg::MODE_RST;
         baud_divisor        <= ubf_pkg::DIV_RST;
      end else if (do_write) begin
         if (aw_addr == ubf_pkg::OFS_MODE && w_strb[0]) begin
            serial_mode_control <= w_data[ubf_pkg::MODE_W-1:0];
         end
         if (aw_addr == ubf_pkg::OFS_DIV) begin
            if (w_strb[0]) begin
               baud_divisor[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
               baud_divisor[15:8] <= w_data[15:8];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= '0;
         s_rresp   <= ubf_pkg::RESP_OKAY;
      end else begin
         s_arready <= ~(ar_take | (s_rvalid & ~s_rready));
         if (ar_take) begin
            s_rvalid <= 1'b1;
            s_rdata  <= '0;
            s_rresp  <= ubf_pkg::RESP_OKAY;
            unique case (s_araddr)
               ubf_pkg::OFS_MODE: s_rdata[ubf_pkg::MODE_W-1:0] <= serial_mode_control;
               ubf_pkg::OFS_DIV:  s_rdata[15:0] <= baud_divisor;
               ubf_pkg::OFS_RXDATA: begin
                  s_rdata[8:0]               <= mem[rd_ptr].data;
                  s_rdata[ubf_pkg::RXD_PERR] <= mem[rd_ptr].perr;
                  s_rdata[ubf_pkg::RXD_FERR] <= mem[rd_ptr].ferr;
                  s_rdata[ubf_pkg::RXD_VALID] <= out_valid;
               end
               ubf_pkg::OFS_STAT: begin
                  s_rdata[ubf_pkg::ST_NEMPTY] <= out_valid;
                  s_rdata[ubf_pkg::ST_FULL]   <= ~push_ready;
                  s_rdata[ubf_pkg::ST_OVR]    <= ovr_flag;
                  s_rdata[ubf_pkg::ST_PERR]   <= perr_flag;
                  s_rdata[ubf_pkg::ST_FERR]   <= ferr_flag;
                  s_rdata[ubf_pkg::ST_IDLE]   <= (rx_state == ubf_pkg::RX_IDLE);
               end
               default: s_rresp <= ubf_pkg::RESP_SLVERR;
            endcase
         end else if (s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // three stages; a change counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_sync  <= 3'h7;
         rx_level <= 1'b1;
      end else begin
         rx_sync <= {rx_sync[1:0], serial_receive_input};
         if (rx_sync[1] == rx_sync[2]) begin
            rx_level <= rx_sync[2];
         end
      end
   end

   // reset holds idle as 1 until the mode register says otherwise
   assign line     = rx_level ^ rx_polarity_invert;
   assign sample   = baud_tick & (sc == bit_last);
   assign half_hit = baud_tick & (sc == half_last);
   assign perr     = (parity_data_select == ubf_pkg::PD_ODD || parity_data_select == ubf_pkg::PD_EVEN)
                   & ((^sh[7:0]) ^ par_bit ^ (parity_data_select == ubf_pkg::PD_ODD));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_state <= ubf_pkg::RX_IDLE;
         sc       <= '0;
         bit_cnt  <= '0;
         stop_cnt <= 1'b0;
         sh       <= '0;
         par_bit  <= 1'b0;
         ferr     <= 1'b0;
      end else begin
         unique case (rx_state)
            ubf_pkg::RX_IDLE: begin
               sc <= '0;
               if (!line) begin
                  rx_state <= ubf_pkg::RX_START;
               end
            end
            ubf_pkg::RX_START: begin
               if (half_hit) begin
                  sc       <= '0;
                  bit_cnt  <= '0;
                  stop_cnt <= 1'b0;
                  ferr     <= 1'b0;
                  sh       <= '0;
                  rx_state <= line ? ubf_pkg::RX_IDLE : ubf_pkg::RX_DATA;
               end else if (baud_tick) begin
                  sc <= sc + 4'h1;
               end
            end
            ubf_pkg::RX_DATA: begin
               if (sample) begin
                  sc          <= '0;
                  sh[bit_cnt] <= line;
                  if (bit_cnt == ((parity_data_select == ubf_pkg::PD_NINE) ? ubf_pkg::LAST_BIT_9
                                                                           : ubf_pkg::LAST_BIT_8)) begin
                     rx_state <= (parity_data_select == ubf_pkg::PD_NONE ||
                                  parity_data_select == ubf_pkg::PD_NINE) ? ubf_pkg::RX_STOP
                                                                          : ubf_pkg::RX_PARITY;
                  end else begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end else if (baud_tick) begin
                  sc <= sc + 4'h1;
               end
            end
            ubf_pkg::RX_PARITY: begin
               if (sample) begin
                  sc       <= '0;
                  par_bit  <= line;
                  rx_state <= ubf_pkg::RX_STOP;
               end else if (baud_tick) begin
                  sc <= sc + 4'h1;
               end
            end
            ubf_pkg::RX_STOP: begin
               if (sample) begin
                  sc <= '0;
                  if (!line) begin
                     ferr <= 1'b1;
                  end
                  if (stop_bit_select && !stop_cnt) begin
                     stop_cnt <= 1'b1;
                  end else begin
                     rx_state <= ubf_pkg::RX_HOLD;
                  end
               end else if (baud_tick) begin
                  sc <= sc + 4'h1;
               end
            end
            ubf_pkg::RX_HOLD: begin
               // a full buffer stalls here; the line is not watched meanwhile
               if (push_ready) begin
                  rx_state <= ubf_pkg::RX_IDLE;
               end
            end
         endcase
      end
   end

   assign push_valid     = (rx_state == ubf_pkg::RX_HOLD);
   assign push_ready     = (count != (PW + 1)'(DEPTH));
   assign out_valid      = (count != '0);
   assign push_word.data = sh;
   assign push_word.perr = perr;
   assign push_word.ferr = ferr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push_valid && push_ready) begin
            mem[wr_ptr] <= push_word;
            wr_ptr      <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
         end
         count <= count + (PW + 1)'(push_valid & push_ready) - (PW + 1)'(pop);
      end
   end

   // write one to clear; a new event in the same cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovr_flag  <= 1'b0;
         perr_flag <= 1'b0;
         ferr_flag <= 1'b0;
      end else begin
         ovr_flag  <= (ovr_flag & ~(stat_wr & w_data[ubf_pkg::ST_OVR]))
                    | (sample & (rx_state == ubf_pkg::RX_STOP) & ~(stop_bit_select & ~stop_cnt) & ~push_ready);
         perr_flag <= (perr_flag & ~(stat_wr & w_data[ubf_pkg::ST_PERR]))
                    | (push_valid & push_ready & perr);
         ferr_flag <= (ferr_flag & ~(stat_wr & w_data[ubf_pkg::ST_FERR]))
                    | (push_valid & push_ready & ferr);
      end
   end

endmodule

// ---- bench/ubf_chk.sv ----
// assertion checker bound to the baud and frame configuration block
`timescale 1ns/100ps
module ubf_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [3:0]  s_awaddr,
   input wire logic        s_awvalid,
   input wire logic        s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0]  s_wstrb,
   input wire logic        s_wvalid,
   input wire logic        s_wready,
   input wire logic [1:0]  s_bresp,
   input wire logic        s_bvalid,
   input wire logic        s_bready,
   input wire logic [3:0]  s_araddr,
   input wire logic        s_arvalid,
   input wire logic        s_arready,
   input wire logic [31:0] s_rdata,
   input wire logic [1:0]  s_rresp,
   input wire logic        s_rvalid,
   input wire logic        s_rready,
   input wire logic        serial_receive_input,
   input wire logic        baud_tick,
   input wire logic        bit_tick
);
   logic [15:0] div;
   logic [16:0] cnt;
   logic [16:0] wcnt;
   logic [1:0]  dirty;
   logic        div_wr;
   logic        mode_wr;
   logic        hs;
   logic [1:0]  bdirty;
   logic [4:0]  tk;
   assign div_wr = s_wvalid && s_wready && s_awaddr == ubf_pkg::OFS_DIV && (&s_wstrb[1:0]);
   assign mode_wr = s_wvalid && s_wready && s_awaddr == ubf_pkg::OFS_MODE && s_wstrb[0];
   // two ticks after a write or reset are irregular, so they are not held to the period
   always_ff @(posedge aclk) begin
      if (!aresetn || div_wr) begin
         div   <= aresetn ? s_wdata[15:0] : ubf_pkg::DIV_RST;
         dirty <= 2'h2;
      end else if (baud_tick && dirty != 2'h0) begin
         dirty <= dirty - 2'h1;
      end
   end
   always_ff @(posedge aclk) begin
      cnt  <= (baud_tick || !aresetn) ? 17'h0 : cnt + 17'h1;
      wcnt <= (div_wr || !aresetn) ? 17'h0 : wcnt + 17'h1;
   end
   // bit ticks around a mode or divisor write straddle two rates, so three are skipped
   always_ff @(posedge aclk) begin
      if (!aresetn || mode_wr || div_wr) begin
         bdirty <= 2'h3;
      end else if (bit_tick && bdirty != 2'h0) begin
         bdirty <= bdirty - 2'h1;
      end
      if (!aresetn || mode_wr) begin
         hs <= aresetn & s_wdata[ubf_pkg::MODE_HSEL];
      end
      tk <= (!aresetn) ? 5'h0 : (bit_tick ? 5'(baud_tick) : tk + 5'(baud_tick));
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_baud_period: assert property (baud_tick && dirty == 2'h0 |-> cnt == {1'b0, div})
      else $error("baud tick period is not divisor plus one");
   a_div_restart: assert property (baud_tick && dirty == 2'h2 |-> wcnt <= {1'b0, div} + 17'h3)
      else $error("baud tick late after divisor write");
   a_bit_pulse: assert property (bit_tick |=> !bit_tick)
      else $error("bit tick longer than one cycle");
   a_bit_spacing: assert property (bit_tick && bdirty == 2'h0
                                   |-> tk == (hs ? 5'(ubf_pkg::PRESCALE_HS) : 5'(ubf_pkg::PRESCALE_STD)))
      else $error("bit tick spacing is not the prescale");
   a_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready)
      else $error("read data missing");
   a_bvalid_drop: assert property (s_bvalid && s_bready |=> !s_bvalid && s_awready)
      else $error("write response not released");
   a_rd_release: assert property (s_rvalid && s_rready |=> !s_rvalid)
      else $error("read data not released");
   a_ar_refuse: assert property (s_rvalid |-> !s_arready)
      else $error("read address taken while data pending");
   a_slverr_zero: assert property (s_rvalid && s_rresp == ubf_pkg::RESP_SLVERR |-> s_rdata == 32'h0)
      else $error("error read returns data");
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_bvalid && !s_rvalid && !baud_tick && !s_awready)
      else $error("outputs active during reset");
endmodule
bind ubf_top ubf_chk i_ubf_chk (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
   .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
   .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
   .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
   .serial_receive_input(serial_receive_input), .baud_tick(baud_tick), .bit_tick(bit_tick));

// ---- bench/ubf_tx_model.sv ----
// remote serial transmitter driving the receive line
`timescale 1ns/100ps
module ubf_tx_model (
   input  wire logic aclk,
   input  wire logic inv,
   output logic      line
);
   logic lvl = 1'b1;
   assign line = lvl ^ inv;
   task automatic put(input logic b, input int cyc);
      lvl <= b;
      repeat (cyc) @(posedge aclk);
   endtask
   // err 1 flips the parity bit, err 2 drives the last stop low
   task automatic send(input logic [8:0] d, input logic [4:0] m, input int cyc, input int err);
      int   i;
      logic p;
      @(posedge aclk);
      put(1'b0, cyc);
      for (i = 0; i < ((m[2:1] == 2'h3) ? 9 : 8); i++) begin
         put(d[i], cyc);
      end
      p = ^d[7:0] ^ m[2] ^ (err == 1);
      if (m[2:1] == 2'h1 || m[2:1] == 2'h2) begin
         put(p, cyc);
      end
      if (m[0]) begin
         put(1'b1, cyc);
      end
      put(err != 2, cyc);
      lvl <= 1'b1;
   endtask
endmodule

// ---- bench/ubf_top_test.sv ----
// self-checking testbench of the baud and frame configuration block
`timescale 1ns/100ps
module ubf_top_test;
   typedef struct packed {
      logic [4:0]  mode;
      logic [15:0] div;
      logic [8:0]  data;
      logic [1:0]  err;
   } ubf_row_s;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        line_inv = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, rx_line, baud_tick, bit_tick;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, rd;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          k;
   ubf_row_s    rows [12] = '{'{5'h00, 16'h1, 9'h0a5, 2'h0}, '{5'h01, 16'h2, 9'h03c, 2'h0},
      '{5'h02, 16'h1, 9'h081, 2'h0}, '{5'h04, 16'h1, 9'h07e, 2'h0}, '{5'h06, 16'h1, 9'h1a5, 2'h0},
      '{5'h08, 16'h3, 9'h05a, 2'h0}, '{5'h10, 16'h1, 9'h0c3, 2'h0}, '{5'h1f, 16'h2, 9'h155, 2'h0},
      '{5'h02, 16'h1, 9'h011, 2'h1}, '{5'h04, 16'h0, 9'h0f0, 2'h1}, '{5'h01, 16'h1, 9'h022, 2'h2},
      '{5'h08, 16'h1, 9'h033, 2'h2}};
   ubf_top i_ubf_top (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
      .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
      .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
      .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .serial_receive_input(rx_line),
      .baud_tick(baud_tick), .bit_tick(bit_tick));
   ubf_tx_model i_tx (.aclk(aclk), .inv(line_inv), .line(rx_line));
   initial begin
      forever #2.5 aclk = ~aclk;
   end
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ready is looked at on the falling edge, so the decision matches the next rising edge
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ah, wh, bh;
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(negedge aclk);
         ah = awready && awvalid; wh = wready && wvalid; bh = bvalid; resp = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
      end while (bh !== 1'b1);
      bready <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      logic ah, rh;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(negedge aclk);
         ah = arready && arvalid; rh = rvalid; rd = rdata; resp = rresp;
         @(posedge aclk);
         if (ah) arvalid <= 1'b0;
      end while (rh !== 1'b1);
      rready <= 1'b0;
   endtask
   task automatic wait_rx();
      do rd_reg(ubf_pkg::OFS_STAT); while (rd[ubf_pkg::ST_NEMPTY] !== 1'b1);
   endtask
   initial begin
      repeat (40000) @(posedge aclk);
      n_mismatch++;
      $display("ERROR watchdog expected finish seen timeout");
      stop_test();
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         wr(ubf_pkg::OFS_MODE, 32'(rows[i].mode), 4'hf);
         wr(ubf_pkg::OFS_DIV, 32'(rows[i].div), 4'hf);
         line_inv <= rows[i].mode[ubf_pkg::MODE_RX_POLARITY_INVERT];
         rd_reg(ubf_pkg::OFS_MODE);
         check("mode", 32'(rows[i].mode), rd);
         // a polarity flip looks like a start bit; let that false start die first
         repeat (64) @(posedge aclk);
         i_tx.send(rows[i].data, rows[i].mode, (rows[i].mode[3] ? 4 : 16) * (32'(rows[i].div) + 1), rows[i].err);
         wait_rx();
         rd_reg(ubf_pkg::OFS_RXDATA);
         check("rxdata", {1'b1, 20'h0, rows[i].err == 2'h2, rows[i].err == 2'h1, rows[i].data}, rd);
      end
      rd_reg(ubf_pkg::OFS_STAT);
      check("status sticky", 32'h18, rd & 32'h18);
      // fill the buffer past full while nobody reads
      wr(ubf_pkg::OFS_STAT, 32'h1c, 4'h1);
      wr(ubf_pkg::OFS_MODE, 32'h0, 4'hf);
      line_inv <= 1'b0;
      wr(ubf_pkg::OFS_DIV, 32'hff, 4'hf);
      repeat (100) @(posedge aclk);
      wr(ubf_pkg::OFS_DIV, 32'h1, 4'hf);
      for (k = 0; k < 3; k++) i_tx.send(9'(8'h10 + k), 5'h00, 32, 0);
      repeat (20) @(posedge aclk);
      rd_reg(ubf_pkg::OFS_STAT);
      check("status full", 32'h7, rd & 32'h3f);
      for (k = 0; k < 3; k++) begin
         rd_reg(ubf_pkg::OFS_RXDATA);
         check("drain", {1'b1, 22'h0, 9'(8'h10 + k)}, rd);
      end
      rd_reg(ubf_pkg::OFS_STAT);
      check("status empty", 32'h24, rd & 32'h3f);
      wr(ubf_pkg::OFS_MODE, 32'h05, 4'hf);
      wr(4'h2, 32'h0, 4'hf);
      check("unaligned resp", 32'(ubf_pkg::RESP_SLVERR), 32'(resp));
      wr(ubf_pkg::OFS_MODE, 32'h0, 4'h0);
      rd_reg(ubf_pkg::OFS_MODE);
      check("mode kept", 32'h05, rd);
      rd_reg(4'h6);
      check("unaligned read", 32'(ubf_pkg::RESP_SLVERR), 32'(resp));
      // second reset in mid-run
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(ubf_pkg::OFS_MODE);
      check("mode reset", 32'(ubf_pkg::MODE_RST), rd);
      rd_reg(ubf_pkg::OFS_DIV);
      check("div reset", 32'(ubf_pkg::DIV_RST), rd);
      stop_test();
   end
endmodule
